// [bench/alt_protection_properties.sv]
// Port checker for the alternator protection block.
// Assumes a bind to alt_protection; it sees only that module's ports.
`timescale 1ns/1ps
module alt_protection_properties
    import alt_prot_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Watched inputs.
    input wire alt_prot_pkg::cfg_t cfg,
    input wire logic jumper60,
    input wire logic [15:0] freqCenti,
    input wire logic shortCircuit,
    // Watched outputs.
    input wire logic [15:0] vScale,
    input wire logic [15:0] alarmFlags,
    input wire logic blocked
);
    // ----------------------------------------
    // Common clocking
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Entry into the blocked state, in two steps.
    sequence s_blockRise;
        !blocked ##1 blocked;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Flags lag inputs by one edge, so the first edge after reset is skipped.
    AST_BLOCK_ZERO: assert property (
        blocked |-> vScale == 16'h0000) else $error("scale not zero");
    AST_BLOCK_HOLD: assert property (
        blocked |=> blocked) else $error("block released");
    AST_BLOCK_CAUSE: assert property (
        s_blockRise |-> $past(shortCircuit)) else $error("block w/o short");
    AST_OK_BIT: assert property (
        $past(reset_n) |-> alarmFlags[BIT_OK] == (alarmFlags[10:0] == 11'h000))
        else $error("ok bit wrong");
    AST_MODE60: assert property (
        $past(reset_n) |-> alarmFlags[BIT_MODE60] ==
        $past(cfg.flag60 | (cfg.jumperEn & jumper60))) else $error("mode bit");
    AST_SHORT_BIT: assert property (
        $past(reset_n) |-> alarmFlags[BIT_SHORT] == $past(shortCircuit))
        else $error("short bit wrong");
    AST_US_LOW: assert property (
        freqCenti < 16'd4000 |=> alarmFlags[BIT_UNDERSPEED])
        else $error("underspeed missed");
    AST_US_HIGH: assert property (
        freqCenti >= 16'd6000 |=> !alarmFlags[BIT_UNDERSPEED])
        else $error("underspeed false");
    AST_OS_LOW: assert property (
        freqCenti <= 16'd5000 |=> !alarmFlags[BIT_OVERSPEED])
        else $error("overspeed false");
    AST_FLOOR: assert property (
        alarmFlags[BIT_UNDERSPEED] && !alarmFlags[BIT_OVER_EXC] && !blocked
        |-> vScale >= VF_FLOOR) else $error("below floor");
endmodule : alt_protection_properties

// [bench/alt_protection_tb.sv]
// Self-checking bench for the alternator protection block.
// Assumes a 10-cycle tick so the thermal and short timers run quickly.
`timescale 1ns/1ps
module alt_protection_tb;
    import alt_prot_pkg::*;
    // One row: frequency, 60 Hz jumper, expected flags and scale.
    typedef struct {
        logic [15:0] f;
        logic m;
        logic [15:0] fl;
        logic [15:0] v;
    } row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cfg_t cfg = 4'h8;
    logic jumper60 = 1'b0;
    logic [15:0] usKnob = 16'h0000;
    logic [15:0] currentLimitKnob = 16'h7FFF;
    logic [15:0] tgtFreq = 16'h0000;
    logic [15:0] loadCur = 16'h0000;
    logic faultReq = 1'b0;
    par_req_t parReq = '0;
    logic [15:0] freqCenti, exCurrent, rdData, vScale, alarmFlags;
    logic shortCircuit, ledOn, blocked;
    int failures = 0;
    int n_tests = 0;
    // Thresholds at reset: under 45/54 Hz, over 55/66 Hz, work slope 9000.
    row_t rows [8] = '{'{16'h1388, 1'b0, 16'h0800, 16'h7FFF},
        '{16'h1193, 1'b0, 16'h0020, 16'h7FDC},
        '{16'h1194, 1'b0, 16'h0800, 16'h7FFF},
        '{16'h157D, 1'b0, 16'h0040, 16'h7FFF},
        '{16'h157C, 1'b0, 16'h0800, 16'h7FFF},
        '{16'h1517, 1'b1, 16'h8020, 16'h7FDC},
        '{16'h19C9, 1'b1, 16'h8040, 16'h7FFF},
        '{16'h1770, 1'b1, 16'h8800, 16'h7FFF}};
    // 100 MHz clock.
    always #5 clk = ~clk;
    alternator_model i_alternator_model (.clk(clk), .reset_n(reset_n),
        .tgtFreq(tgtFreq), .loadCur(loadCur), .faultReq(faultReq),
        .blocked(blocked), .freqCenti(freqCenti), .exCurrent(exCurrent),
        .shortCircuit(shortCircuit));
    alt_protection #(.TICK_CYCLES(10)) i_alt_protection (.clk(clk),
        .reset_n(reset_n), .cfg(cfg), .jumper60(jumper60), .usKnob(usKnob),
        .currentLimitKnob(currentLimitKnob), .freqCenti(freqCenti),
        .exCurrent(exCurrent), .shortCircuit(shortCircuit), .parReq(parReq),
        .rdData(rdData), .vScale(vScale), .alarmFlags(alarmFlags),
        .ledOn(ledOn), .blocked(blocked));
    // Compare and count.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Let n edges land, then step off the edge.
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : go
    // Model latches on one edge, the block on the next.
    task automatic setf(input logic [15:0] f, input logic m);
        @(posedge clk);
        tgtFreq <= f;
        jumper60 <= m;
        go(4);
    endtask : setf
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        @(posedge clk);
        parReq.wrEn <= 1'b1;
        parReq.wrIdx <= idx;
        parReq.wrData <= d;
        @(posedge clk);
        parReq.wrEn <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
        @(posedge clk);
        parReq.rdIdx <= idx;
        go(2);
        chk(rdData, exp);
    endtask : rd
    // Bit 18 the indicator, 17 a reduced scale, 16 the block, rest flags.
    task automatic waitFlag(input int b, input logic v, input int lim);
        logic [18:0] w;
        for (int k = 0; k < lim; k++) begin
            w = {ledOn, vScale != 16'h7FFF, blocked, alarmFlags};
            if (w[b] === v) begin
                n_tests++;
                return;
            end
            go(1);
        end
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, w[b], v);
        complete_run();
    endtask : waitFlag
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge clk);
        chk(vScale, 16'h0000);
        chk(alarmFlags, 16'h0000);
        reset_n <= 1'b1;
        go(3);
        chk(vScale, 16'h2000);
        setf(16'h1193, 1'b0);
        chk(vScale, 16'h7FE8);
        waitFlag(18, 1'b1, 1500);
        $display("reset and start-up done");
        foreach (rows[i]) begin
            setf(rows[i].f, rows[i].m);
            chk(alarmFlags, rows[i].fl);
            chk(vScale, rows[i].v);
        end
        $display("table done");
        rd(IDX_VF_WORK_SLOPE, 16'h2328);
        rd(IDX_VF_STARTUP_SLOPE, 16'h1770);
        rd(IDX_US_THR_READBACK, 16'h4000);
        rd(6'd0, 16'h0000);
        wr(IDX_THERMAL_ESTIMATE, 16'h1234);
        rd(IDX_THERMAL_ESTIMATE, 16'h0000);
        wr(IDX_VF_WORK_SLOPE, 16'h0000);
        setf(16'h1193, 1'b0);
        chk(vScale, 16'h7FFF);
        @(posedge clk);
        cfg.usKnobEn <= 1'b1;
        usKnob <= 16'h7FFF;
        setf(16'h1386, 1'b0);
        chk(alarmFlags, 16'h0020);
        rd(IDX_US_THR_READBACK, 16'h7FFF);
        usKnob <= 16'h0000;
        setf(16'h1004, 1'b0);
        chk(alarmFlags, 16'h0800);
        cfg.usKnobEn <= 1'b0;
        wr(IDX_OVERSPEED_THR, 16'h8001);
        setf(16'h1389, 1'b0);
        chk(alarmFlags, 16'h0040);
        setf(16'h1388, 1'b0);
        chk(alarmFlags, 16'h0800);
        $display("registers and thresholds done");
        wr(IDX_THERMAL_LIMIT, 16'h0010);
        loadCur <= 16'h1000;
        waitFlag(BIT_OVER_EXC, 1'b1, 2000);
        waitFlag(17, 1'b1, 500);
        loadCur <= 16'h0000;
        waitFlag(BIT_OVER_EXC, 1'b0, 5000);
        waitFlag(17, 1'b0, 20000);
        $display("thermal limit done");
        wr(IDX_SHORT_CIRCUIT_TIME, 16'h0001);
        faultReq <= 1'b1;
        go(500);
        chk({15'h0000, blocked}, 16'h0000);
        waitFlag(16, 1'b1, 2000);
        chk(vScale, 16'h0000);
        $display("short circuit done");
        complete_run();
    end
endmodule : alt_protection_tb
bind alt_protection alt_protection_properties i_props (.clk(clk),
    .reset_n(reset_n), .cfg(cfg), .jumper60(jumper60),
    .freqCenti(freqCenti), .shortCircuit(shortCircuit), .vScale(vScale),
    .alarmFlags(alarmFlags), .blocked(blocked));

// [bench/alternator_model.sv]
// Behavioural alternator: frequency, field current and short circuit.
// Assumes the bench sets targets; outputs are registered on clk.
`timescale 1ns/1ps
module alternator_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Targets from the bench.
    input wire logic [15:0] tgtFreq,
    input wire logic [15:0] loadCur,
    input wire logic faultReq,
    // Regulator side.
    input wire logic blocked,
    output logic [15:0] freqCenti,
    output logic [15:0] exCurrent,
    output logic shortCircuit
);
    // A blocked regulator removes excitation, so field current collapses.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freqCenti <= 16'h0000;
            exCurrent <= 16'h0000;
            shortCircuit <= 1'b0;
        end else begin
            freqCenti <= tgtFreq;
            exCurrent <= blocked ? 16'h0000 : loadCur;
            shortCircuit <= faultReq;
        end
    end
endmodule : alternator_model

// [logic/alt_prot_pkg.sv]
// Package for the alternator protection logic: parameter indices,
// breakpoints, fixed-point scaling, timing constants and carrier types.
// Assumes a 100 MHz system clock and frequency measured in 0.01 Hz units.
package alt_prot_pkg;

    // ----------------------------------------------------------------
    // Parameter and status location indices (terminal addresses)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_AUX_SUPPLY_RATIO = 6'd14;
    localparam logic [5:0] IDX_UNDERSPEED_THR = 6'd21;
    localparam logic [5:0] IDX_THERMAL_LIMIT = 6'd22;
    localparam logic [5:0] IDX_VF_WORK_SLOPE = 6'd23;
    localparam logic [5:0] IDX_VF_STARTUP_SLOPE = 6'd24;
    localparam logic [5:0] IDX_SHORT_CIRCUIT_TIME = 6'd25;
    localparam logic [5:0] IDX_OVERSPEED_THR = 6'd26;
    localparam logic [5:0] IDX_OX_PROP_GAIN = 6'd28;
    localparam logic [5:0] IDX_OX_INT_GAIN = 6'd29;
    localparam logic [5:0] IDX_US_THR_READBACK = 6'd34;
    localparam logic [5:0] IDX_ALARM_FLAGS = 6'd38;
    localparam logic [5:0] IDX_THERMAL_ESTIMATE = 6'd45;

    // ----------------------------------------------------------------
    // Reset values of the parameters
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_VF_WORK_SLOPE = 16'h2328;
    localparam logic [15:0] RST_VF_STARTUP_SLOPE = 16'h1770;
    localparam logic [15:0] RST_UNDERSPEED_THR = 16'h4000;
    localparam logic [15:0] RST_THERMAL_LIMIT = 16'h7FFF;
    localparam logic [15:0] RST_OVERSPEED_THR = 16'h0000;
    localparam logic [15:0] RST_AUX_SUPPLY_RATIO = 16'h0000;
    localparam logic [15:0] RST_SHORT_CIRCUIT_TIME = 16'h0000;
    localparam logic [15:0] RST_OX_PROP_GAIN = 16'h0400;
    localparam logic [15:0] RST_OX_INT_GAIN = 16'h0040;

    // ----------------------------------------------------------------
    // Alarm flag word bit positions (bit n means alarm n+1)
    // ----------------------------------------------------------------
    localparam int BIT_SHORT = 3;
    localparam int BIT_OVER_EXC = 4;
    localparam int BIT_UNDERSPEED = 5;
    localparam int BIT_OVERSPEED = 6;
    localparam int BIT_OK = 11;
    localparam int BIT_MODE60 = 15;

    // ----------------------------------------------------------------
    // Threshold breakpoints in 0.01 Hz, and interpolation mid-point
    // ----------------------------------------------------------------
    localparam logic [15:0] US_MID_50 = 16'h1194;
    localparam logic [15:0] US_MID_60 = 16'h1518;
    localparam logic [15:0] OS_MID_50 = 16'h157C;
    localparam logic [15:0] OS_MID_60 = 16'h19C8;
    localparam logic [15:0] SPAN_50 = 16'h01F4;
    localparam logic [15:0] SPAN_60 = 16'h0258;
    localparam logic [15:0] SETTING_MID = 16'h4000;
    localparam logic [15:0] FULL_SCALE = 16'h7FFF;

    // ----------------------------------------------------------------
    // Loop scaling and timing
    // ----------------------------------------------------------------
    localparam int EST_SHIFT = 10;
    localparam int GAIN_SHIFT = 12;
    localparam int SLOPE_SHIFT = 8;
    localparam logic [15:0] VF_FLOOR = 16'h2000;
    localparam int CLK_MHZ = 100;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
    localparam int TENTH_TIME_MS = 100;
    localparam logic [6:0] TICKS_PER_TENTH =
        7'((TENTH_TIME_MS * 1000) / TICK_TIME_US);

    // Protection phase, Gray coded along start, run, block.
    typedef enum logic [1:0] {
        PH_START = 2'b00,
        PH_RUN = 2'b01,
        PH_BLOCK = 2'b11
    } phase_t;

    // Configuration flags that steer threshold sources.
    typedef struct packed {
        logic jumperEn;
        logic flag60;
        logic usKnobEn;
        logic ampKnobEn;
    } cfg_t;

    // Parameter access request from the serial terminal.
    typedef struct packed {
        logic wrEn;
        logic [5:0] wrIdx;
        logic [15:0] wrData;
        logic [5:0] rdIdx;
    } par_req_t;

endpackage : alt_prot_pkg

// [logic/alt_protection.sv]
// Alternator protection logic: rotor temperature estimate with an
// over-excitation limiting loop, underspeed V/f reduction, overspeed
// threshold and short-circuit blocking timer.
// Assumes frequency, excitation current and knob values arrive already
// digitised and synchronous to clk; the terminal accesses parameters
// by location index.
`timescale 1ns/1ps

module alt_protection #(
    parameter int TICK_CYCLES = alt_prot_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Configuration and operator controls.
    input wire alt_prot_pkg::cfg_t cfg,
    input wire logic jumper60,
    input wire logic [15:0] usKnob,
    input wire logic [15:0] currentLimitKnob,
    // Machine measurements.
    input wire logic [15:0] freqCenti,
    input wire logic [15:0] exCurrent,
    input wire logic shortCircuit,
    // Terminal parameter access.
    input wire alt_prot_pkg::par_req_t parReq,
    output logic [15:0] rdData,
    // Regulator outputs.
    output logic [15:0] vScale,
    output logic [15:0] alarmFlags,
    output logic ledOn,
    output logic blocked
);
    import alt_prot_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Writable parameters held by the device.
    logic [15:0] auxRatio_ff;
    logic [15:0] usThrPar_ff;
    logic [15:0] thermLimPar_ff;
    logic [15:0] workSlope_ff;
    logic [15:0] startSlope_ff;
    logic [15:0] scTime_ff;
    logic [15:0] osThrPar_ff;
    logic [15:0] oxKp_ff;
    logic [15:0] oxKi_ff;

    // Loop state.
    logic [15:0] estimate_ff;      // Temperature estimate.
    logic signed [17:0] oxInt_ff;  // Limiting loop integrator.
    phase_t phase_ff;              // Start-up, running or blocked.
    phase_t nxt_phase;
    logic [31:0] tickCnt_ff;       // Prescaler for the slow tick.
    logic tick_ff;                 // One-cycle slow tick.
    logic [6:0] tenthCnt_ff;       // Ticks within one tenth second.
    logic [7:0] scTenths_ff;       // Tenths spent in short circuit.
    logic [10:0] ledCnt_ff;        // Indicator pattern counter.

    // Output registers.
    logic blocked_ff;              // Block state.
    logic [15:0] rdData_ff;
    logic [15:0] vScale_ff;
    logic [15:0] alarmFlags_ff;
    logic ledOn_ff;

    // ----------------------------------------------------------------
    // Threshold interpolation
    // ----------------------------------------------------------------
    // Signed offset from the mid setting, scaled by the span and
    // shifted; one form serves both thresholds.
    function automatic logic [15:0] interp(
        input logic [15:0] mid,
        input logic [15:0] span,
        input logic signed [16:0] delta,
        input logic wide
    );
        logic signed [33:0] prod;
        prod = 34'(delta * $signed({1'b0, span}));
        prod = wide ? (prod >>> 15) : (prod >>> 14);
        interp = 16'(mid + prod[15:0]);
    endfunction : interp

    // ----------------------------------------------------------------
    // Threshold selection
    // ----------------------------------------------------------------
    // The jumper counts only while its reading is enabled.
    wire mode60 = (cfg.jumperEn & jumper60) | cfg.flag60;

    // Knob or parameter supplies the underspeed setting.
    wire [15:0] usSetting = cfg.usKnobEn ? usKnob : usThrPar_ff;
    // Knob or parameter supplies the thermal limit.
    wire [15:0] thermLimit =
        cfg.ampKnobEn ? currentLimitKnob : thermLimPar_ff;
    // Both thresholds share the span of the active mode.
    wire [15:0] span = mode60 ? SPAN_60 : SPAN_50;

    // Offset of the 15-bit setting from its mid point, 16384.
    wire signed [16:0] usDelta =
        $signed({2'b00, usSetting[14:0]}) - $signed({1'b0, SETTING_MID});
    // Piecewise linear about 45 or 54 Hz, 14-bit span each side.
    wire [15:0] usThr = interp(mode60 ? US_MID_60 : US_MID_50, span,
        usDelta, 1'b0);

    // Overspeed setting is taken as signed about 55 or 66 Hz.
    wire [15:0] osThr = interp(mode60 ? OS_MID_60 : OS_MID_50, span,
        $signed({osThrPar_ff[15], osThrPar_ff}), 1'b1);

    // ----------------------------------------------------------------
    // Underspeed V/f reduction
    // ----------------------------------------------------------------
    // Strict: a frequency on the threshold is healthy.
    wire underspeed = freqCenti < usThr;
    wire [15:0] freqGap = underspeed ? 16'(usThr - freqCenti) : 16'h0000;
    // Start-up slope holds until the frequency first reaches the threshold.
    wire [15:0] slope =
        (phase_ff == PH_START) ? startSlope_ff : workSlope_ff;

    // Product in 32 bits, then clamped.
    wire [31:0] vfRedFull = (slope * freqGap) >> SLOPE_SHIFT;
    wire [15:0] vfRed =
        (vfRedFull > 32'(FULL_SCALE)) ? FULL_SCALE : vfRedFull[15:0];
    // A zero slope yields zero reduction and full voltage.
    wire [15:0] vfRaw = 16'(FULL_SCALE - vfRed);

    // Floor so the regulator's own supply stays usable; an auxiliary
    // winding lower than the output raises it.
    wire [31:0] floorFull =
        32'(VF_FLOOR) + ((32'(VF_FLOOR) * auxRatio_ff) >> 15);
    wire [15:0] vfFloor =
        (floorFull > 32'(FULL_SCALE)) ? FULL_SCALE : floorFull[15:0];
    // Reduction is bounded by the frequency-independent floor, which
    // avoids collapsing excitation supply at very low speed.
    wire [15:0] vfScale = !underspeed ? FULL_SCALE
        : ((vfRaw < vfFloor) ? vfFloor : vfRaw);

    // ----------------------------------------------------------------
    // Thermal estimate and over-excitation loop
    // ----------------------------------------------------------------
    // Gap between the present current and the estimate.
    wire signed [16:0] estStep =
        $signed({2'b00, exCurrent[14:0]}) - $signed({1'b0, estimate_ff});
    // First-order step: a fraction of the gap each tick.
    wire [15:0] nxt_estimate =
        16'(estimate_ff + 16'(estStep >>> EST_SHIFT));

    // Positive means above the limit.
    wire signed [16:0] oxErr =
        $signed({1'b0, estimate_ff}) - $signed({1'b0, thermLimit});
    wire overExc = !oxErr[16] && (oxErr != 17'sd0);
    // One shift for both gains keeps their ratio.
    wire signed [34:0] kiTerm =
        35'(oxErr * $signed({1'b0, oxKi_ff})) >>> GAIN_SHIFT;
    wire signed [34:0] kpTerm =
        35'(oxErr * $signed({1'b0, oxKp_ff})) >>> GAIN_SHIFT;

    // Integrator winds down below the limit, so voltage recovers.
    wire signed [34:0] intSum = 35'(oxInt_ff) + kiTerm;
    wire signed [17:0] nxt_oxInt = intSum[34] ? 18'sd0
        : (intSum > 35'sd32767) ? 18'sd32767 : intSum[17:0];
    // Proportional action only while the alarm stands.
    wire signed [34:0] cutSum = 35'(oxInt_ff) + (overExc ? kpTerm : '0);
    wire [15:0] oxCut = cutSum[34] ? 16'h0000
        : (cutSum > 35'sd32767) ? FULL_SCALE : cutSum[15:0];

    // The limiting loop cuts from whatever V/f would allow; zero
    // goes out on the edge that blocks, level with the block flag.
    wire [15:0] nxt_vScale = (nxt_phase == PH_BLOCK) ? 16'h0000
        : ((oxCut >= vfScale) ? 16'h0000 : 16'(vfScale - oxCut));

    // ----------------------------------------------------------------
    // Alarm word and indicator
    // ----------------------------------------------------------------
    // Overspeed is strict as well.
    wire overspeed = freqCenti > osThr;
    // Blocking also clears the OK bit.
    wire anyAlarm = shortCircuit | overExc | underspeed | overspeed |
        (phase_ff == PH_BLOCK);
    wire [15:0] nxt_alarmFlags = (16'(shortCircuit) << BIT_SHORT)
        | (16'(overExc) << BIT_OVER_EXC)
        | (16'(underspeed) << BIT_UNDERSPEED)
        | (16'(overspeed) << BIT_OVERSPEED)
        | (16'(!anyAlarm) << BIT_OK)
        | (16'(mode60) << BIT_MODE60);

    // Slow 50 % blink unless underspeed or over-excitation, which blink faster.
    wire nxt_ledOn = underspeed ? ledCnt_ff[7]
        : overExc ? ledCnt_ff[9] : ledCnt_ff[10];

    // ----------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------

    // Unknown locations read as zero.
    logic [15:0] nxt_rdData;
    always_comb begin
        case (parReq.rdIdx)
            IDX_AUX_SUPPLY_RATIO: nxt_rdData = auxRatio_ff;
            IDX_UNDERSPEED_THR: nxt_rdData = usThrPar_ff;
            IDX_THERMAL_LIMIT: nxt_rdData = thermLimPar_ff;
            IDX_VF_WORK_SLOPE: nxt_rdData = workSlope_ff;
            IDX_VF_STARTUP_SLOPE: nxt_rdData = startSlope_ff;
            IDX_SHORT_CIRCUIT_TIME: nxt_rdData = scTime_ff;
            IDX_OVERSPEED_THR: nxt_rdData = osThrPar_ff;
            IDX_OX_PROP_GAIN: nxt_rdData = oxKp_ff;
            IDX_OX_INT_GAIN: nxt_rdData = oxKi_ff;
            IDX_US_THR_READBACK: nxt_rdData = usSetting;
            IDX_ALARM_FLAGS: nxt_rdData = alarmFlags_ff;
            IDX_THERMAL_ESTIMATE: nxt_rdData = estimate_ff;
            default: nxt_rdData = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    // Blocking is final until reset; start-up ends when the frequency
    // first reaches the underspeed threshold.
    wire scExpired = (scTime_ff[7:0] != 8'h00) && shortCircuit &&
        (scTenths_ff >= scTime_ff[7:0]);

    // Expiry blocks from either live phase.
    always_comb begin
        case (phase_ff)
            PH_START: nxt_phase = scExpired ? PH_BLOCK
                : (!underspeed ? PH_RUN : PH_START);
            PH_RUN: nxt_phase = scExpired ? PH_BLOCK : PH_RUN;
            PH_BLOCK: nxt_phase = PH_BLOCK;
            default: nxt_phase = PH_START;
        endcase
    end

    // ----------------------------------------------------------------
    // Parameter storage
    // ----------------------------------------------------------------
    // Writes to read-only or unknown locations are ignored.
    // Only writable locations decode.
    wire wrOk = parReq.wrEn;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            auxRatio_ff <= RST_AUX_SUPPLY_RATIO;
            usThrPar_ff <= RST_UNDERSPEED_THR;
            thermLimPar_ff <= RST_THERMAL_LIMIT;
            workSlope_ff <= RST_VF_WORK_SLOPE;
            startSlope_ff <= RST_VF_STARTUP_SLOPE;
            scTime_ff <= RST_SHORT_CIRCUIT_TIME;
            osThrPar_ff <= RST_OVERSPEED_THR;
            oxKp_ff <= RST_OX_PROP_GAIN;
            oxKi_ff <= RST_OX_INT_GAIN;
        end else if (wrOk) begin
            case (parReq.wrIdx)
                IDX_AUX_SUPPLY_RATIO: auxRatio_ff <= parReq.wrData;
                IDX_UNDERSPEED_THR: usThrPar_ff <= parReq.wrData;
                IDX_THERMAL_LIMIT: thermLimPar_ff <= parReq.wrData;
                IDX_VF_WORK_SLOPE: workSlope_ff <= parReq.wrData;
                IDX_VF_STARTUP_SLOPE: startSlope_ff <= parReq.wrData;
                IDX_SHORT_CIRCUIT_TIME: scTime_ff <= parReq.wrData;
                IDX_OVERSPEED_THR: osThrPar_ff <= parReq.wrData;
                IDX_OX_PROP_GAIN: oxKp_ff <= parReq.wrData;
                IDX_OX_INT_GAIN: oxKi_ff <= parReq.wrData;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Slow tick prescaler
    // ----------------------------------------------------------------
    // Every slow process steps on this tick.

    wire tickWrap = tickCnt_ff == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else begin
            tickCnt_ff <= tickWrap ? 32'h0000_0000 : tickCnt_ff + 32'h1;
            tick_ff <= tickWrap;
        end
    end

    // ----------------------------------------------------------------
    // Estimator and limiting loop, advanced once per tick
    // ----------------------------------------------------------------
    // The blink counter shares this tick.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            estimate_ff <= 16'h0000;
            oxInt_ff <= 18'sd0;
            ledCnt_ff <= 11'h000;
        end else if (tick_ff) begin
            estimate_ff <= nxt_estimate;
            oxInt_ff <= nxt_oxInt;
            ledCnt_ff <= 11'(ledCnt_ff + 11'h001);
        end
    end

    // ----------------------------------------------------------------
    // Short-circuit timer in tenths of a second
    // ----------------------------------------------------------------
    // The count restarts whenever the short is removed; a setting of
    // zero never expires.
    wire tenthWrap = tenthCnt_ff == 7'(TICKS_PER_TENTH - 7'd1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tenthCnt_ff <= 7'h00;
            scTenths_ff <= 8'h00;
        end else if (!shortCircuit) begin
            tenthCnt_ff <= 7'h00;
            scTenths_ff <= 8'h00;
        end else if (tick_ff) begin
            tenthCnt_ff <= tenthWrap ? 7'h00 : 7'(tenthCnt_ff + 7'h01);
            // Saturate at 255 tenths rather than wrap.
            if (tenthWrap && scTenths_ff != 8'hFF) begin
                scTenths_ff <= 8'(scTenths_ff + 8'h01);
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase and output registers
    // ----------------------------------------------------------------
    // Every output is registered here, so none can glitch.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= PH_START;
            blocked_ff <= 1'b0;
            vScale_ff <= 16'h0000;
            alarmFlags_ff <= 16'h0000;
            ledOn_ff <= 1'b0;
            rdData_ff <= 16'h0000;
        end else begin
            phase_ff <= nxt_phase;
            blocked_ff <= (nxt_phase == PH_BLOCK);
            vScale_ff <= nxt_vScale;
            alarmFlags_ff <= nxt_alarmFlags;
            ledOn_ff <= nxt_ledOn;
            rdData_ff <= nxt_rdData;
        end
    end

    // Outputs straight from flip-flops.
    assign rdData = rdData_ff;
    assign vScale = vScale_ff;
    assign alarmFlags = alarmFlags_ff;
    assign ledOn = ledOn_ff;
    assign blocked = blocked_ff;

endmodule : alt_protection
